// ===== include/orc_defs.svh
`ifndef ORC_DEFS_SVH
`define ORC_DEFS_SVH

`define ORC_OFF_OSC 12'h000
`define ORC_OFF_DIV 12'h004
`define ORC_OFF_FBD 12'h008
`define ORC_OFF_TUN 12'h00C

`define ORC_B_CUR 14:12
`define ORC_B_NXT 10:8
`define ORC_B_LOCK 7
`define ORC_B_PSL 6
`define ORC_B_PLLOK 5
`define ORC_B_CF 3
`define ORC_B_SECONDARY_OSC 1
`define ORC_B_REQ 0
`define ORC_OSC_UNIMPL_MASK 32'hFFFF_8814

`define ORC_B_ROI 15
`define ORC_B_DOZE 14:12
`define ORC_B_SLOW_RATIO_ENABLE 11
`define ORC_B_RC_POSTSCALE_SEL 10:8
`define ORC_B_POST 7:6
`define ORC_B_PRE 4:0
`define ORC_B_MULT 8:0
`define ORC_B_TRIM 5:0

`define ORC_RST_DOZE 3'h3
`define ORC_RST_RC_POSTSCALE_SEL 3'h0
`define ORC_RST_POST 2'h1
`define ORC_RST_PRE 5'h00
`define ORC_RST_MULT 9'h030
`define ORC_RST_TRIM 6'h00

`define ORC_B_MODE_OFF 1
`define ORC_MODE_SW_ONLY 2'h1
`define ORC_SRC_RC_PLL 3'h1
`define ORC_SRC_PRI_PLL 3'h3

`define ORC_FRC_MAX 3'h7
`define ORC_FRC_MAX_EXP 4'h8
`define ORC_POST_D2 2'h0
`define ORC_POST_D4 2'h1
`define ORC_POST_D8 2'h3
`define ORC_PRE_BASE 6'h02
`define ORC_MULT_BASE 10'h002
`define ORC_FCY_EXP 4'h1

`define ORC_INIT_WAIT 2'h2
`define ORC_INIT_LEAVE 2'h3

`endif

// ===== include/orc_pkg.sv
package orc_pkg;

  typedef enum logic [1:0] {
    ORC_INIT = 2'h0,
    ORC_IDLE = 2'h1,
    ORC_WAIT = 2'h2,
    ORC_CLR = 2'h3
  } orc_fsm_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } orc_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } orc_apb_rsp_s;

  typedef struct packed {
    logic [2:0] src;
    logic [1:0] mode;
    logic pll_lock;
    logic fail;
    logic done;
  } orc_pins_s;

  typedef struct packed {
    orc_pins_s s1;
    orc_pins_s s2;
  } orc_sync_s;

  typedef struct packed {
    logic switch_start;
    logic [2:0] target_src;
    logic [2:0] current_src;
    logic secondary_osc_enable;
    logic pin_select_lock;
    logic clock_fail_flag;
  } orc_out_s;

  typedef struct packed {
    logic [2:0] doze;
    logic slow_ratio_enable;
    logic [2:0] rc_postscale_sel;
    logic [1:0] pll_out_divider;
    logic [4:0] pll_in_divider;
    logic [8:0] pll_multiplier;
    logic [5:0] rc_trim_code;
  } orc_div_s;

  typedef struct packed {
    logic [3:0] periph_exp;
    logic [3:0] rc_post_exp;
    logic [1:0] pll_post_exp;
    logic pll_post_bad;
    logic [5:0] pll_in_div;
    logic [9:0] pll_mult;
    logic signed [5:0] rc_trim_steps;
  } orc_ratio_s;

  typedef struct packed {
    orc_fsm_e fsm;
    logic [1:0] cnt;
    logic [1:0] mode;
    logic [2:0] cur;
    logic [2:0] nxt;
    logic lock;
    logic psl;
    logic cf;
    logic secondary_osc;
    logic req;
    logic recover_on_irq;
    logic done_d;
    orc_div_s div;
    logic [31:0] rdata;
    logic err;
  } orc_state_s;

endpackage

// ===== core/orc_sync.sv
module orc_sync
(
  input logic clock,
  input logic rst,
  input logic clk_en,
  input orc_pkg::orc_pins_s din,
  output orc_pkg::orc_pins_s dout
);

  orc_pkg::orc_sync_s sync_reg;
  orc_pkg::orc_sync_s sync_next;

  // Only the second stage is visible, so no logic ever sees a metastable value.
  always_comb
  begin
    sync_next = sync_reg;
    sync_next.s1 = din;
    sync_next.s2 = sync_reg.s1;
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      sync_reg <= '0;
    end
    else if (clk_en)
    begin
      sync_reg <= sync_next;
    end
  end

  assign dout = sync_reg.s2;

endmodule // orc_sync

// ===== core/orc_ratio.sv
`include "orc_defs.svh"

module orc_ratio
(
  input orc_pkg::orc_div_s div,
  output orc_pkg::orc_ratio_s ratio
);

  always_comb
  begin
    ratio = '0;
    if (div.slow_ratio_enable)
    begin
      ratio.periph_exp = {1'b0, div.doze} + `ORC_FCY_EXP;
    end
    else
    begin
      ratio.periph_exp = `ORC_FCY_EXP;
    end
    if (div.rc_postscale_sel == `ORC_FRC_MAX)
    begin
      ratio.rc_post_exp = `ORC_FRC_MAX_EXP;
    end
    else
    begin
      ratio.rc_post_exp = {1'b0, div.rc_postscale_sel};
    end
    // The reserved postscaler code is flagged and falls back to divide by 4.
    case (div.pll_out_divider)
      `ORC_POST_D2: ratio.pll_post_exp = 2'h1;
      `ORC_POST_D4: ratio.pll_post_exp = 2'h2;
      `ORC_POST_D8: ratio.pll_post_exp = 2'h3;
      default:
      begin
        ratio.pll_post_exp = 2'h2;
        ratio.pll_post_bad = 1'b1;
      end
    endcase
    ratio.pll_in_div = {1'b0, div.pll_in_divider} + `ORC_PRE_BASE;
    ratio.pll_mult = {1'b0, div.pll_multiplier} + `ORC_MULT_BASE;
    ratio.rc_trim_steps = signed'(div.rc_trim_code);
  end

endmodule // orc_ratio

// ===== core/orc_osc_ctl.sv
// Functional notes
// - Read-only current source field at bits 14:12, eight source codes.
// - Writable next source field at bits 10:8, same encoding.
// - Writing 1 to bit 0 requests a switch; held until complete.
// - In mode 01, set-only lock bit 7 blocks switching.
// - Pin-select lock bit 6 rejects pin-select writes while set.
// - PLL lock bit 5 is 1 only when PLL runs and is locked.
// - Clock-fail flag set by monitor, cleared only by software, resets 0.
// - Bit 1 enables the secondary oscillator.
// - With recover-on-interrupt set, interrupts clear the slow ratio enable.
// - Doze field divides by two to the field value, reset 011.
// - Slow ratio enable selects doze ratio, else ratio is 1:1.
// - RC postscaler divides by two to the code, 111 gives 256.
// - PLL output divider 2, 4 or 8; code 10 is reserved.
// - PLL input divider is field plus two, 2 to 33.
// - PLL multiplier is field plus two, reset gives 50.
// - Signed six-bit RC trim code, 0.375 percent per step.
// - Only power-on reset restores the registers.
// - Unimplemented bits read as zero.
// - Source fields load from the configuration straps at power-on.
// - Mode 1x disables switching and monitor; 01 switching only; 00 both. The code gates only switching; the fail monitor runs in every mode.
// - Instruction clock is system clock over two; doze applies after it.
`include "orc_defs.svh"

module orc_osc_ctl
(
  input logic clock,
  input logic rst,
  input logic clk_en,
  input orc_pkg::orc_apb_req_s apb_req,
  output orc_pkg::orc_apb_rsp_s apb_rsp,
  input orc_pkg::orc_pins_s pins,
  input logic irq_event,
  input logic pps_wr_req,
  output logic pps_wr_grant,
  output orc_pkg::orc_out_s osc_out,
  output orc_pkg::orc_ratio_s ratio
);

  localparam orc_pkg::orc_state_s STATE_RST = '{
    fsm: orc_pkg::ORC_INIT,
    cnt: 2'h0,
    mode: 2'h0,
    cur: 3'h0,
    nxt: 3'h0,
    lock: 1'b0,
    psl: 1'b0,
    cf: 1'b0,
    secondary_osc: 1'b0,
    req: 1'b0,
    recover_on_irq: 1'b0,
    done_d: 1'b0,
    div: '{
      doze: `ORC_RST_DOZE,
      slow_ratio_enable: 1'b0,
      rc_postscale_sel: `ORC_RST_RC_POSTSCALE_SEL,
      pll_out_divider: `ORC_RST_POST,
      pll_in_divider: `ORC_RST_PRE,
      pll_multiplier: `ORC_RST_MULT,
      rc_trim_code: `ORC_RST_TRIM
    },
    rdata: 32'h0000_0000,
    err: 1'b0
  };

  orc_pkg::orc_state_s state_reg;
  orc_pkg::orc_state_s state_next;
  orc_pkg::orc_pins_s pins_s2;
  logic ready;
  logic access;
  logic setup;
  logic sw_allowed;
  logic pll_src;
  logic done_rise;
  logic rd_hit;
  logic [31:0] rd_word;
  logic [31:0] wd;

  orc_sync u_sync
  (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .din(pins),
    .dout(pins_s2)
  );

  orc_ratio u_ratio
  (
    .div(state_reg.div),
    .ratio(ratio)
  );

  always_comb
  begin
    ready = clk_en && (state_reg.fsm != orc_pkg::ORC_INIT);
    access = apb_req.psel && apb_req.penable && ready;
    setup = apb_req.psel && !access;
    wd = apb_req.pwdata;
    pll_src = (state_reg.cur == `ORC_SRC_RC_PLL) || (state_reg.cur == `ORC_SRC_PRI_PLL);
    sw_allowed = !state_reg.mode[`ORC_B_MODE_OFF];
    if ((state_reg.mode == `ORC_MODE_SW_ONLY) && state_reg.lock)
    begin
      sw_allowed = 1'b0;
    end
    done_rise = pins_s2.done && !state_reg.done_d;
  end

  // Read word assembly; every bit not named here stays zero.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (apb_req.paddr)
      `ORC_OFF_OSC:
      begin
        rd_word[`ORC_B_CUR] = state_reg.cur;
        rd_word[`ORC_B_NXT] = state_reg.nxt;
        rd_word[`ORC_B_LOCK] = state_reg.lock;
        rd_word[`ORC_B_PSL] = state_reg.psl;
        rd_word[`ORC_B_PLLOK] = pins_s2.pll_lock && pll_src;
        rd_word[`ORC_B_CF] = state_reg.cf;
        rd_word[`ORC_B_SECONDARY_OSC] = state_reg.secondary_osc;
        rd_word[`ORC_B_REQ] = state_reg.req;
      end
      `ORC_OFF_DIV:
      begin
        rd_word[`ORC_B_ROI] = state_reg.recover_on_irq;
        rd_word[`ORC_B_DOZE] = state_reg.div.doze;
        rd_word[`ORC_B_SLOW_RATIO_ENABLE] = state_reg.div.slow_ratio_enable;
        rd_word[`ORC_B_RC_POSTSCALE_SEL] = state_reg.div.rc_postscale_sel;
        rd_word[`ORC_B_POST] = state_reg.div.pll_out_divider;
        rd_word[`ORC_B_PRE] = state_reg.div.pll_in_divider;
      end
      `ORC_OFF_FBD:
      begin
        rd_word[`ORC_B_MULT] = state_reg.div.pll_multiplier;
      end
      `ORC_OFF_TUN:
      begin
        rd_word[`ORC_B_TRIM] = state_reg.div.rc_trim_code;
      end
      default:
      begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always_comb
  begin
    logic cf_clr;
    cf_clr = 1'b0;
    state_next = state_reg;
    state_next.done_d = pins_s2.done;
    case (state_reg.fsm)
      orc_pkg::ORC_INIT:
      begin
        // Straps are taken only once the synchroniser holds settled values.
        // Start-up ends one edge later, so a read stalled here captures the loaded sources.
        state_next.cnt = state_reg.cnt + 2'h1;
        if (state_reg.cnt == `ORC_INIT_WAIT)
        begin
          state_next.cur = pins_s2.src;
          state_next.nxt = pins_s2.src;
          state_next.mode = pins_s2.mode;
        end
        if (state_reg.cnt == `ORC_INIT_LEAVE)
        begin
          state_next.fsm = orc_pkg::ORC_IDLE;
        end
      end
      orc_pkg::ORC_IDLE:
      begin
        state_next.fsm = orc_pkg::ORC_IDLE;
      end
      orc_pkg::ORC_WAIT:
      begin
        if (done_rise)
        begin
          state_next.cur = state_reg.nxt;
          state_next.fsm = orc_pkg::ORC_CLR;
        end
      end
      orc_pkg::ORC_CLR:
      begin
        state_next.req = 1'b0;
        state_next.fsm = orc_pkg::ORC_IDLE;
      end
      default:
      begin
        state_next.fsm = orc_pkg::ORC_IDLE;
      end
    endcase
    if (access && apb_req.pwrite)
    begin
      case (apb_req.paddr)
        `ORC_OFF_OSC:
        begin
          state_next.nxt = wd[`ORC_B_NXT];
          state_next.lock = state_reg.lock || wd[`ORC_B_LOCK];
          state_next.psl = wd[`ORC_B_PSL];
          state_next.secondary_osc = wd[`ORC_B_SECONDARY_OSC];
          cf_clr = !wd[`ORC_B_CF];
          // A request while locked in mode 01, disabled or already switching is dropped.
          if (wd[`ORC_B_REQ] && sw_allowed && (state_reg.fsm == orc_pkg::ORC_IDLE))
          begin
            state_next.req = 1'b1;
            state_next.fsm = orc_pkg::ORC_WAIT;
          end
        end
        `ORC_OFF_DIV:
        begin
          state_next.recover_on_irq = wd[`ORC_B_ROI];
          state_next.div.doze = wd[`ORC_B_DOZE];
          state_next.div.slow_ratio_enable = wd[`ORC_B_SLOW_RATIO_ENABLE];
          state_next.div.rc_postscale_sel = wd[`ORC_B_RC_POSTSCALE_SEL];
          state_next.div.pll_out_divider = wd[`ORC_B_POST];
          state_next.div.pll_in_divider = wd[`ORC_B_PRE];
        end
        `ORC_OFF_FBD:
        begin
          state_next.div.pll_multiplier = wd[`ORC_B_MULT];
        end
        `ORC_OFF_TUN:
        begin
          state_next.div.rc_trim_code = wd[`ORC_B_TRIM];
        end
        default:
        begin
          cf_clr = 1'b0;
        end
      endcase
    end
    // Hardware events win over a software write in the same cycle.
    if (irq_event && state_reg.recover_on_irq)
    begin
      state_next.div.slow_ratio_enable = 1'b0;
    end
    if (pins_s2.fail)
    begin
      state_next.cf = 1'b1;
    end
    else if (cf_clr)
    begin
      state_next.cf = 1'b0;
    end
    // Read data is sampled while the access waits, so it is stable when ready rises.
    if (setup)
    begin
      state_next.rdata = rd_word;
      state_next.err = !rd_hit;
    end
  end

  // The only reset is power-on; no other reset source reaches this state.
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= STATE_RST;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
    end
  end

  always_comb
  begin
    apb_rsp.prdata = state_reg.rdata;
    apb_rsp.pready = ready;
    apb_rsp.pslverr = state_reg.err;
    pps_wr_grant = pps_wr_req && !state_reg.psl;
    osc_out.switch_start = state_reg.req;
    osc_out.target_src = state_reg.nxt;
    osc_out.current_src = state_reg.cur;
    osc_out.secondary_osc_enable = state_reg.secondary_osc;
    osc_out.pin_select_lock = state_reg.psl;
    osc_out.clock_fail_flag = state_reg.cf;
  end

  default clocking cb @(posedge clock);
  endclocking

  default disable iff (rst);

  sequence s_sw_done;
    clk_en && (state_reg.fsm == orc_pkg::ORC_WAIT) && done_rise;
  endsequence

  sequence s_req_write;
    clk_en && access && apb_req.pwrite && (apb_req.paddr == `ORC_OFF_OSC) && wd[`ORC_B_REQ];
  endsequence

  sequence s_osc_setup;
    clk_en && setup && (apb_req.paddr == `ORC_OFF_OSC);
  endsequence

  a_done_copy:
    assert property (s_sw_done |=> state_reg.cur == $past(state_reg.nxt))
    else $error("Current source not updated on switch completion.");

  a_req_clear:
    assert property (s_sw_done ##1 clk_en |=> !state_reg.req)
    else $error("Switch request not cleared after completion.");

  a_req_hold:
    assert property ((state_reg.fsm == orc_pkg::ORC_WAIT) |-> state_reg.req)
    else $error("Switch request dropped before completion.");

  a_lock_sticky:
    assert property (state_reg.lock |=> state_reg.lock)
    else $error("Switch lock cleared without power-on reset.");

  a_lock_blocks:
    assert property (s_req_write and (state_reg.mode == `ORC_MODE_SW_ONLY) and state_reg.lock
      and (state_reg.fsm == orc_pkg::ORC_IDLE) |=> !state_reg.req)
    else $error("Switch request accepted while locked.");

  a_fail_set:
    assert property (clk_en && pins_s2.fail |=> state_reg.cf)
    else $error("Clock fail event lost.");

  a_pps_block:
    assert property (state_reg.psl |-> !pps_wr_grant)
    else $error("Pin-select write granted while locked.");

  a_roi_clear:
    assert property (clk_en && irq_event && state_reg.recover_on_irq |=> !state_reg.div.slow_ratio_enable)
    else $error("Interrupt did not clear slow ratio enable.");

  a_doze_off:
    assert property (!state_reg.div.slow_ratio_enable |-> ratio.periph_exp == `ORC_FCY_EXP)
    else $error("Ratio not 1:1 with slow ratio disabled.");

  a_unimpl_zero:
    assert property (s_osc_setup |=> (apb_rsp.prdata & `ORC_OSC_UNIMPL_MASK) == 32'h0000_0000)
    else $error("Unimplemented control bits read nonzero.");

  a_pll_off:
    assert property (s_osc_setup and !pll_src |=> !apb_rsp.prdata[`ORC_B_PLLOK])
    else $error("PLL lock shown while PLL not in use.");

endmodule // orc_osc_ctl

// ===== verification/orc_tb.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  logic clock;
  logic rst;
  logic clk_en;
  logic irq_event;
  logic pps_wr_req;
  logic pps_wr_grant;
  orc_pkg::orc_apb_req_s req;
  orc_pkg::orc_apb_rsp_s rsp;
  orc_pkg::orc_pins_s pins;
  orc_pkg::orc_out_s osc_out;
  orc_pkg::orc_ratio_s ratio;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  logic [31:0] d;
  logic [31:0] f;
  logic [31:0] t;
  int n_errors;
  int compares;
  int cycles;

  orc_osc_ctl dut
  (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .apb_req(req),
    .apb_rsp(rsp),
    .pins(pins),
    .irq_event(irq_event),
    .pps_wr_req(pps_wr_req),
    .pps_wr_grant(pps_wr_grant),
    .osc_out(osc_out),
    .ratio(ratio)
  );

  initial
  begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic conclude();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The request stands until a rising edge at which pready is high; that edge completes
  // the transfer, and only then is the request released.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge clock);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= a;
    req.pwdata <= wd;
    @(posedge clock);
    req.penable <= 1'b1;
    do
      @(posedge clock);
    while (rsp.pready !== 1'b1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] ex);
    exp_q.push_back(ex);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  task automatic por(input logic [2:0] src, input logic [1:0] mode, input int n);
    pins.src <= src;
    pins.mode <= mode;
    rst <= 1'b1;
    repeat (n) @(posedge clock);
    rst <= 1'b0;
  endtask

  function automatic logic [32:0] rexp(input logic [31:0] dv, input logic [31:0] fv,
                                       input logic [31:0] tv);
    orc_pkg::orc_ratio_s r;
    r.periph_exp = dv[11] ? {1'b0, dv[14:12]} + 4'h1 : 4'h1;
    r.rc_post_exp = (dv[10:8] == 3'h7) ? 4'h8 : {1'b0, dv[10:8]};
    r.pll_post_exp = (dv[7:6] == 2'h3) ? 2'h3 : ((dv[7:6] == 2'h0) ? 2'h1 : 2'h2);
    r.pll_post_bad = (dv[7:6] == 2'h2);
    r.pll_in_div = {1'b0, dv[4:0]} + 6'h02;
    r.pll_mult = {1'b0, fv[8:0]} + 10'h002;
    r.rc_trim_steps = tv[5:0];
    return r;
  endfunction

  task automatic pulse_done();
    @(posedge clock);
    pins.done <= 1'b1;
    repeat (6) @(posedge clock);
    pins.done <= 1'b0;
    @(posedge clock);
  endtask

  // Read data and error are taken at the rising edge that completes the access.
  always @(posedge clock)
  begin
    if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite)
    begin
      e = exp_q.pop_front();
      chk(rsp.prdata, e[31:0]);
      chk(rsp.pslverr, e[32]);
    end
  end

  // Ceiling is nearly ninety times the length of the sequence below.
  always @(posedge clock)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      n_errors++;
      conclude();
    end
  end

  initial
  begin
    req = '0;
    pins = '0;
    rst = 1'b1;
    clk_en = 1'b1;
    irq_event = 1'b0;
    pps_wr_req = 1'b0;
    pins.pll_lock = 1'b1;
    void'($urandom(3923));
    por(3'h1, 2'h1, 20);
    rd(12'h000, 33'h0_0000_1120);
    rd(12'h004, 33'h0_0000_3040);
    rd(12'h008, 33'h0_0000_0030);
    rd(12'h00C, 33'h0_0000_0000);
    rd(12'h010, 33'h1_0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      d = $urandom() & 32'hFFFF_7FFF;
      f = $urandom();
      t = $urandom();
      wr(12'h004, d);
      wr(12'h008, f);
      wr(12'h00C, t);
      // Recover-on-interrupt is clear here, so the interrupt must change nothing.
      irq_event <= 1'b1;
      @(posedge clock);
      irq_event <= 1'b0;
      rd(12'h004, {1'b0, d & 32'h0000_7FDF});
      rd(12'h008, {1'b0, f & 32'h0000_01FF});
      rd(12'h00C, {1'b0, t & 32'h0000_003F});
      @(negedge clock);
      chk(ratio, rexp(d, f, t));
    end
    wr(12'h000, 32'h0000_0301);
    @(negedge clock);
    chk(osc_out.switch_start, 1'b1);
    chk(osc_out.target_src, 3'h3);
    pulse_done();
    @(negedge clock);
    chk(osc_out.current_src, 3'h3);
    chk(osc_out.switch_start, 1'b0);
    rd(12'h000, 33'h0_0000_3320);
    wr(12'h000, 32'h0000_0380);
    wr(12'h000, 32'h0000_0281);
    @(negedge clock);
    chk(osc_out.switch_start, 1'b0);
    wr(12'h000, 32'h0000_0200);
    rd(12'h000, 33'h0_0000_32A0);
    wr(12'h000, 32'h0000_0240);
    pps_wr_req <= 1'b1;
    @(negedge clock);
    chk(pps_wr_grant, 1'b0);
    chk(osc_out.pin_select_lock, 1'b1);
    wr(12'h000, 32'h0000_0202);
    @(negedge clock);
    chk(pps_wr_grant, 1'b1);
    chk(osc_out.secondary_osc_enable, 1'b1);
    // A low clock enable freezes the synchroniser too, so the failure is not seen yet.
    @(posedge clock);
    clk_en <= 1'b0;
    pins.fail <= 1'b1;
    repeat (5) @(posedge clock);
    clk_en <= 1'b1;
    @(negedge clock);
    chk(osc_out.clock_fail_flag, 1'b0);
    repeat (5) @(negedge clock);
    chk(osc_out.clock_fail_flag, 1'b1);
    rd(12'h000, 33'h0_0000_32AA);
    pins.fail <= 1'b0;
    pins.pll_lock <= 1'b0;
    repeat (5) @(posedge clock);
    rd(12'h000, 33'h0_0000_328A);
    wr(12'h000, 32'h0000_0202);
    @(negedge clock);
    chk(osc_out.clock_fail_flag, 1'b0);
    wr(12'h004, 32'h0000_B800);
    @(negedge clock);
    chk(ratio.periph_exp, 4'h4);
    @(posedge clock);
    irq_event <= 1'b1;
    @(posedge clock);
    irq_event <= 1'b0;
    rd(12'h004, 33'h0_0000_B000);
    @(negedge clock);
    chk(ratio.periph_exp, 4'h1);
    wr(12'h008, 32'h0000_01FF);
    por(3'h4, 2'h2, 2);
    rd(12'h008, 33'h0_0000_0030);
    rd(12'h004, 33'h0_0000_3040);
    rd(12'h000, 33'h0_0000_4400);
    wr(12'h000, 32'h0000_0101);
    @(negedge clock);
    chk(osc_out.switch_start, 1'b0);
    @(posedge clock);
    por(3'h6, 2'h0, 2);
    rd(12'h000, 33'h0_0000_6600);
    wr(12'h000, 32'h0000_0580);
    wr(12'h000, 32'h0000_0581);
    @(negedge clock);
    chk(osc_out.switch_start, 1'b1);
    pulse_done();
    @(negedge clock);
    chk(osc_out.current_src, 3'h5);
    repeat (3) @(posedge clock);
    chk(exp_q.size(), 0);
    conclude();
  end
endmodule // testbench
